/* lcdc_pkg.sv */
// package: register map, field layout and reset values of the lcd display control block
package lcdc_pkg;

  // register byte addresses (low 16 bits of haddr)
  localparam logic [15:0] ADDR_CLK_SEL  = 16'h5063;
  localparam logic [15:0] ADDR_DISP_CTL = 16'h50a0;
  localparam logic [15:0] ADDR_CONTRAST = 16'h50a1;
  localparam logic [15:0] ADDR_FRM_DUTY = 16'h50a2;
  localparam logic [15:0] ADDR_VREG     = 16'h50a3;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'h50a5;
  localparam logic [15:0] ADDR_IRQ_FLAG = 16'h50a6;
  localparam logic [1:0]  WORD_LSB      = 2'h0;

  // display states
  localparam logic [1:0] DSP_OFF    = 2'h0;
  localparam logic [1:0] DSP_NORMAL = 2'h1;
  localparam logic [1:0] DSP_ALLON  = 2'h2;
  localparam logic [1:0] DSP_ALLOFF = 2'h3;

  // clock sources
  localparam logic [1:0] SRC_INTERNAL = 2'h0;
  localparam logic [1:0] SRC_LOWSPEED = 2'h1;
  localparam logic [1:0] SRC_HIGHSPD  = 2'h2;

  // duty codes
  localparam logic [1:0] DUTY_8  = 2'h0;
  localparam logic [1:0] DUTY_16 = 2'h1;
  localparam logic [1:0] DUTY_24 = 2'h3;

  // divider codes; 1/32 is code 0, 1/512 code 4
  localparam logic [2:0] DIV_MAX_CODE = 3'h4;
  localparam int         DIV_BASE_LOG = 5;
  localparam int         DIV_CNT_W    = 9;

  // reset values
  localparam logic [1:0] RST_DISPLAY  = DSP_OFF;
  localparam logic [3:0] RST_CONTRAST = 4'h7;
  localparam logic [1:0] RST_SOURCE   = SRC_LOWSPEED;
  localparam logic [2:0] RST_DIVIDER  = 3'h0;
  localparam logic [1:0] RST_DUTY     = DUTY_24;
  localparam logic [3:0] RST_FRMCOUNT = 4'h3;

  // frame period = 4 * (count + 1) panel clocks per common line
  localparam int FRAME_MULT = 4;

  // field positions inside the register byte
  localparam int POS_SEG_ORDER = 7;
  localparam int POS_COM_ORDER = 6;
  localparam int POS_AREA      = 5;
  localparam int POS_POLARITY  = 4;
  localparam int POS_DSP_STATE = 0;
  localparam int POS_DIVIDER   = 4;
  localparam int POS_SOURCE    = 2;
  localparam int POS_GATE      = 0;
  localparam int POS_CONTRAST  = 0;
  localparam int POS_FRM_COUNT = 4;
  localparam int POS_DUTY      = 0;
  localparam int POS_HEAVY     = 4;
  localparam int POS_VC_SEL    = 0;
  localparam int POS_IRQ_BIT   = 0;

  // last common line index for each duty
  localparam logic [4:0] LAST_COM_24 = 5'h17;
  localparam logic [4:0] LAST_COM_16 = 5'h0f;
  localparam logic [4:0] LAST_COM_8  = 5'h07;

  typedef struct packed {
    logic       segAscending;
    logic       comAscending;
    logic       areaSelect;
    logic       polarityNormal;
    logic [1:0] displayState;
  } lcdc_disp_s;

  typedef struct packed {
    logic [2:0] divider;
    logic [1:0] source;
    logic       gate;
  } lcdc_clk_s;

  typedef struct packed {
    logic       regulatorOn;
    logic [3:0] contrastLevel;
    logic [3:0] refLevel;
  } lcdc_drive_s;

endpackage : lcdc_pkg

/* lcdc_top.sv */
// lcd display control: ahb-lite registers, clock select/divide, frame timing, drive overrides
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1 - display state field decodes to off, normal, all-on dynamic, all-off static.
// R2 - display off stops regulator drive and grounds all four reference voltages.
// R3 - all-on and all-off override drive waveform; display memory left untouched.
// R4 - display state returns to off on reset and on sleep instruction.
// R5 - software keeps state off until clock stable, configured and reaching driver.
// R6 - four-bit contrast gives sixteen levels, 0xf darkest, 0x0 lightest.
// R7 - contrast field loads 0x7 at reset.
// R8 - reverse bit at 0 inverts every pixel; at 1 normal polarity.
// R9 - inversion ignored in all-off, applied in all-on.
// R10 - frame flag set once every frame.
// R11 - interrupt request only when flag and enable both 1; enable resets 0.
// R12 - software clears flag in handler and before enabling interrupt.
// R13 - registers eight bits; reserved bits written zero, read zero.
// R14 - divider selects 1/32 to 1/512 for internal or high-speed source.
// R15 - low-speed source used undivided, divider ignored.
// R16 - source select: internal 0, low-speed 1 default, high-speed 2.
// R17 - clock gate resets 0 stopping clock; 1 passes clock to driver.
// R18 - segment order bit D7, default 1 ascending, 0 descending.
// R19 - common order bit D6, default 1 ascending, 0 descending.
// R20 - area select chooses memory area in 1/24 or 1/16 duty.
// R21 - flag set on frame rising edge, cleared by writing 1.
// R22 - duty field: 1/24 code 3 default, 1/16 code 1, 1/8 code 0.
// R23 - frame derived from panel clock by 4*(count+1) times duty lines.
// R24 - software changes source and divider only while the gate is off.
module lcdc_top (
  // system
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        sleepExec,
  // oscillator enables, one-cycle ticks synchronous to clk_sys
  input  wire logic        internalOscTick,
  input  wire logic        lowSpeedOscTick,
  input  wire logic        highSpeedOscTick,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // driver side
  output logic             panelClockTick,
  output lcdc_pkg::lcdc_disp_s  dispCtl,
  output lcdc_pkg::lcdc_drive_s driveCtl,
  output logic             pixelInvert,
  output logic             pixelForceOn,
  output logic             pixelForceOff,
  output logic             commonStatic,
  output logic             areaActive,
  output logic             frameSignal,
  output logic [4:0]       commonIndex,
  output logic             frameIrq
);

  ////////////////////////////////////////////////////////////////////////////
  // register state
  lcdc_pkg::lcdc_disp_s dispCtl_ff;
  lcdc_pkg::lcdc_clk_s  clkCtl_ff;
  logic [3:0]           contrast_ff;
  logic [3:0]           frameCount_ff;
  logic [1:0]           duty_ff;
  logic                 heavyLoad_ff;
  logic                 vcSelect_ff;
  logic                 irqEnable_ff;
  logic                 frameFlag_ff;

  // ahb address-phase capture
  logic                 wrPend_ff;
  logic [15:0]          wrAddr_ff;
  logic [31:0]          rdData_ff;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire        addrPhase = hsel & hready & htrans[1];
  wire        rdReq     = addrPhase & ~hwrite;
  wire        wrReq     = addrPhase & hwrite;
  wire [15:0] reqAddr   = haddr[15:0];
  wire [7:0]  wb        = hwdata[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // write data split into fields; reserved bits simply dropped [R13]
  wire       wSegOrder = wb[lcdc_pkg::POS_SEG_ORDER];
  wire       wComOrder = wb[lcdc_pkg::POS_COM_ORDER];
  wire       wArea     = wb[lcdc_pkg::POS_AREA];
  wire       wPolarity = wb[lcdc_pkg::POS_POLARITY];
  wire [1:0] wState    = wb[lcdc_pkg::POS_DSP_STATE +: 2];
  wire [2:0] wDivider  = wb[lcdc_pkg::POS_DIVIDER +: 3];
  wire [1:0] wSource   = wb[lcdc_pkg::POS_SOURCE +: 2];
  wire       wGate     = wb[lcdc_pkg::POS_GATE];
  wire [3:0] wContrast = wb[lcdc_pkg::POS_CONTRAST +: 4];
  wire [3:0] wFrmCount = wb[lcdc_pkg::POS_FRM_COUNT +: 4];
  wire [1:0] wDuty     = wb[lcdc_pkg::POS_DUTY +: 2];
  wire       wHeavy    = wb[lcdc_pkg::POS_HEAVY];
  wire       wVcSel    = wb[lcdc_pkg::POS_VC_SEL];
  wire       wIrqBit   = wb[lcdc_pkg::POS_IRQ_BIT];

  wire wrClk   = wrPend_ff & (wrAddr_ff == lcdc_pkg::ADDR_CLK_SEL);
  wire wrDisp  = wrPend_ff & (wrAddr_ff == lcdc_pkg::ADDR_DISP_CTL);
  wire wrCont  = wrPend_ff & (wrAddr_ff == lcdc_pkg::ADDR_CONTRAST);
  wire wrFrm   = wrPend_ff & (wrAddr_ff == lcdc_pkg::ADDR_FRM_DUTY);
  wire wrVreg  = wrPend_ff & (wrAddr_ff == lcdc_pkg::ADDR_VREG);
  wire wrMask  = wrPend_ff & (wrAddr_ff == lcdc_pkg::ADDR_IRQ_MASK);
  wire wrFlag  = wrPend_ff & (wrAddr_ff == lcdc_pkg::ADDR_IRQ_FLAG);

  // reserved bits read zero [R13]
  wire [7:0] rdClk  = {1'b0, clkCtl_ff.divider, clkCtl_ff.source, 1'b0, clkCtl_ff.gate};
  wire [7:0] rdDisp = {dispCtl_ff.segAscending, dispCtl_ff.comAscending, dispCtl_ff.areaSelect,
                       dispCtl_ff.polarityNormal, 2'b00, dispCtl_ff.displayState};
  wire [7:0] rdCont = {4'h0, contrast_ff};
  wire [7:0] rdFrm  = {frameCount_ff, 2'b00, duty_ff};
  wire [7:0] rdVreg = {3'b000, heavyLoad_ff, 3'b000, vcSelect_ff};
  wire [7:0] rdMask = {7'h00, irqEnable_ff};
  wire [7:0] rdFlag = {7'h00, frameFlag_ff};

  // unmapped addresses read zero and ignore writes
  wire [7:0] rdSel =
    (reqAddr == lcdc_pkg::ADDR_CLK_SEL)  ? rdClk  :
    (reqAddr == lcdc_pkg::ADDR_DISP_CTL) ? rdDisp :
    (reqAddr == lcdc_pkg::ADDR_CONTRAST) ? rdCont :
    (reqAddr == lcdc_pkg::ADDR_FRM_DUTY) ? rdFrm  :
    (reqAddr == lcdc_pkg::ADDR_VREG)     ? rdVreg :
    (reqAddr == lcdc_pkg::ADDR_IRQ_MASK) ? rdMask :
    (reqAddr == lcdc_pkg::ADDR_IRQ_FLAG) ? rdFlag : 8'h00;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdData_ff;

  // address phase remembered for the data phase that carries hwdata
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wrPend_ff <= 1'b0;
    end else begin
      wrPend_ff <= wrReq;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wrAddr_ff <= 16'h0000;
    end else begin
      wrAddr_ff <= reqAddr;
    end
  end

  // read data stands one cycle only, zero otherwise, so stale bytes never linger
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdData_ff <= 32'h0000_0000;
    end else begin
      rdData_ff <= rdReq ? {24'h00_0000, rdSel} : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers, one short process per register
  // sleep clears only the display state; order, area and polarity survive it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dispCtl_ff.segAscending   <= 1'b1;                      // [R18]
      dispCtl_ff.comAscending   <= 1'b1;                      // [R19]
      dispCtl_ff.areaSelect     <= 1'b0;                      // [R20]
      dispCtl_ff.polarityNormal <= 1'b1;                      // [R8]
      dispCtl_ff.displayState   <= lcdc_pkg::RST_DISPLAY;     // [R4]
    end else if (sleepExec) begin
      dispCtl_ff.displayState   <= lcdc_pkg::DSP_OFF;         // [R4]
    end else if (wrDisp) begin
      dispCtl_ff.segAscending   <= wSegOrder;                 // [R18]
      dispCtl_ff.comAscending   <= wComOrder;                 // [R19]
      dispCtl_ff.areaSelect     <= wArea;                     // [R20]
      dispCtl_ff.polarityNormal <= wPolarity;                 // [R8]
      dispCtl_ff.displayState   <= wState;                    // [R1]
    end
  end

  // no glitch guard on source changes: software keeps the gate off meanwhile
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      clkCtl_ff.divider <= lcdc_pkg::RST_DIVIDER;              // [R14]
      clkCtl_ff.source  <= lcdc_pkg::RST_SOURCE;               // [R16]
      clkCtl_ff.gate    <= 1'b0;                               // [R17]
    end else if (wrClk) begin
      clkCtl_ff.divider <= wDivider;                           // [R14]
      clkCtl_ff.source  <= wSource;                            // [R16]
      clkCtl_ff.gate    <= wGate;                              // [R17]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      contrast_ff <= lcdc_pkg::RST_CONTRAST;                   // [R7]
    end else if (wrCont) begin
      contrast_ff <= wContrast;                                // [R6]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      frameCount_ff <= lcdc_pkg::RST_FRMCOUNT;
      duty_ff       <= lcdc_pkg::RST_DUTY;                     // [R22]
    end else if (wrFrm) begin
      frameCount_ff <= wFrmCount;                              // [R23]
      duty_ff       <= wDuty;                                  // [R22]
    end
  end

  // regulator bits are only stored and read back over the bus; no output port carries them
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      heavyLoad_ff <= 1'b0;
      vcSelect_ff  <= 1'b0;
    end else if (wrVreg) begin
      heavyLoad_ff <= wHeavy;
      vcSelect_ff  <= wVcSel;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irqEnable_ff <= 1'b0;                                    // [R11]
    end else if (wrMask) begin
      irqEnable_ff <= wIrqBit;                                 // [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock source select and divider
  logic [lcdc_pkg::DIV_CNT_W-1:0] divCnt_ff;
  logic                           srcTick;
  always_comb begin
    case (clkCtl_ff.source)                                    // [R16]
      lcdc_pkg::SRC_INTERNAL: srcTick = internalOscTick;
      lcdc_pkg::SRC_LOWSPEED: srcTick = lowSpeedOscTick;
      lcdc_pkg::SRC_HIGHSPD:  srcTick = highSpeedOscTick;
      default:                srcTick = 1'b0;
    endcase
  end

  // reserved divider codes stall the clock rather than guess a ratio
  wire       divValid = clkCtl_ff.divider <= lcdc_pkg::DIV_MAX_CODE;
  wire [3:0] divLog   = 4'(lcdc_pkg::DIV_BASE_LOG) + {1'b0, clkCtl_ff.divider};
  wire [lcdc_pkg::DIV_CNT_W-1:0] divLast =
    lcdc_pkg::DIV_CNT_W'((10'd1 << divLog) - 10'd1);
  wire divWrap = srcTick & divValid & (divCnt_ff >= divLast);   // [R14]
  wire undivided = clkCtl_ff.source == lcdc_pkg::SRC_LOWSPEED;
  wire nxt_panelTick = clkCtl_ff.gate & (undivided ? srcTick : divWrap); // [R15] [R17]

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      divCnt_ff      <= '0;
    end else if (!clkCtl_ff.gate || undivided) begin
      divCnt_ff      <= '0;
    end else if (srcTick) begin
      divCnt_ff      <= divWrap ? '0 : divCnt_ff + 1'b1;
    end
  end

  assign panelClockTick = nxt_panelTick;

  ////////////////////////////////////////////////////////////////////////////
  // frame timing: each common line lasts 4*(count+1) panel clocks
  logic [5:0] lineCnt_ff;
  logic [4:0] comIdx_ff;
  logic       frame_ff;
  logic       framePrev_ff;

  wire [5:0] lineLast = 6'(lcdc_pkg::FRAME_MULT * (int'(frameCount_ff) + 1) - 1); // [R23]
  logic [4:0] comLast;
  always_comb begin
    case (duty_ff)                                             // [R22]
      lcdc_pkg::DUTY_24: comLast = lcdc_pkg::LAST_COM_24;
      lcdc_pkg::DUTY_16: comLast = lcdc_pkg::LAST_COM_16;
      lcdc_pkg::DUTY_8:  comLast = lcdc_pkg::LAST_COM_8;
      default:           comLast = lcdc_pkg::LAST_COM_24;
    endcase
  end
  wire lineEnd  = panelClockTick & (lineCnt_ff >= lineLast);
  wire frameEnd = lineEnd & (comIdx_ff >= comLast);

  // >= compares keep a shrunken count from running past its end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lineCnt_ff <= 6'h00;
      comIdx_ff  <= 5'h00;
    end else if (lineEnd) begin
      lineCnt_ff <= 6'h00;
      comIdx_ff  <= frameEnd ? 5'h00 : comIdx_ff + 5'h01;     // [R22]
    end else if (panelClockTick) begin
      lineCnt_ff <= lineCnt_ff + 6'h01;                        // [R23]
    end
  end

  // frame signal high during the first common line
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      frame_ff <= 1'b0;
    end else if (lineEnd) begin
      frame_ff <= frameEnd;                                    // [R23]
    end
  end

  // delayed copy for the edge detect; resets low like frame_ff, so no false edge
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      framePrev_ff <= 1'b0;
    end else begin
      framePrev_ff <= frame_ff;
    end
  end

  assign frameSignal = frame_ff;
  assign commonIndex = comIdx_ff;

  ////////////////////////////////////////////////////////////////////////////
  // frame flag: set wins over a same-cycle clear
  wire frameRise = frame_ff & ~framePrev_ff;                    // [R21]
  wire flagClr   = wrFlag & wIrqBit;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      frameFlag_ff <= 1'b0;
    end else if (frameRise) begin
      frameFlag_ff <= 1'b1;                                    // [R10] [R21]
    end else if (flagClr) begin
      frameFlag_ff <= 1'b0;                                    // [R21]
    end
  end

  assign frameIrq = frameFlag_ff & irqEnable_ff;                // [R11]

  ////////////////////////////////////////////////////////////////////////////
  // drive overrides; display memory is never written from here
  wire [1:0] st       = dispCtl_ff.displayState;
  wire       isAllOn  = st == lcdc_pkg::DSP_ALLON;              // [R1]
  wire       isAllOff = st == lcdc_pkg::DSP_ALLOFF;             // [R1]
  wire       isOff    = st == lcdc_pkg::DSP_OFF;                // [R1]
  assign dispCtl       = dispCtl_ff;
  assign pixelForceOn  = isAllOn;                               // [R3]
  assign pixelForceOff = isAllOff;                              // [R3]
  assign commonStatic  = pixelForceOff;                         // [R3]
  assign pixelInvert   = ~dispCtl_ff.polarityNormal & ~pixelForceOff; // [R8] [R9]
  // area select only meaningful at 1/24 and 1/16 duty
  assign areaActive    = dispCtl_ff.areaSelect & (duty_ff != lcdc_pkg::DUTY_8); // [R20]

  wire regOn = ~isOff;                                          // [R2]
  assign driveCtl.regulatorOn   = regOn;
  assign driveCtl.contrastLevel = contrast_ff;                  // [R6]
  assign driveCtl.refLevel      = regOn ? contrast_ff : 4'h0;   // [R2]

endmodule // lcdc_top

`default_nettype wire

/* lcdc_chk.sv */
// checker: port-level assertions for the lcd display control block
`timescale 1ns/1ps
`default_nettype none
module lcdc_chk (
  // system
  input wire logic                  clk_sys,
  input wire logic                  rst_n,
  input wire logic                  sleepExec,
  // bus
  input wire logic [31:0]           hrdata,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  // driver side
  input wire lcdc_pkg::lcdc_disp_s  dispCtl,
  input wire lcdc_pkg::lcdc_drive_s driveCtl,
  input wire logic                  pixelInvert,
  input wire logic                  pixelForceOn,
  input wire logic                  pixelForceOff,
  input wire logic                  commonStatic,
  input wire logic                  areaActive
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_sleep;
    sleepExec;
  endsequence
  a_force_on:
    assert property (pixelForceOn == (dispCtl.displayState == lcdc_pkg::DSP_ALLON)) else $error("force on wrong");
  a_force_off:
    assert property ((pixelForceOff == (dispCtl.displayState == lcdc_pkg::DSP_ALLOFF))
      && (commonStatic == pixelForceOff)) else $error("force off or static wrong");
  a_off_ground:
    assert property (dispCtl.displayState == lcdc_pkg::DSP_OFF |-> driveCtl.refLevel == 4'h0
      && !driveCtl.regulatorOn) else $error("reference not grounded");
  a_inv_gate:
    assert property (pixelInvert == (!dispCtl.polarityNormal && dispCtl.displayState != lcdc_pkg::DSP_ALLOFF))
      else $error("inversion wrong");
  a_sleep_off:
    assert property (s_sleep |=> dispCtl.displayState == lcdc_pkg::DSP_OFF) else $error("sleep kept display");
  a_rd_upper:
    assert property (hrdata[31:8] == 24'h00_0000) else $error("upper read data set");
  a_area_gate:
    assert property (areaActive |-> dispCtl.areaSelect) else $error("area without select");
  a_bus_okay:
    assert property (hreadyout && !hresp) else $error("bus stalled or error");
endmodule // lcdc_chk
bind lcdc_top lcdc_chk i_lcdc_chk (.clk_sys, .rst_n, .sleepExec, .hrdata, .hreadyout, .hresp, .dispCtl,
  .driveCtl, .pixelInvert, .pixelForceOn, .pixelForceOff, .commonStatic, .areaActive);
`default_nettype wire

/* lcdc_panel.sv */
// partner: panel electrodes counting clock ticks and frame starts
`timescale 1ns/1ps
`default_nettype none
module lcdc_panel (
  input wire logic clk_sys,
  input wire logic clr,
  input wire logic panelClockTick,
  input wire logic frameSignal,
  output var int   tickCount,
  output var int   frameCount
);
  logic frameLast_ff;
  // a frame counts at its rising edge only
  always_ff @(posedge clk_sys) begin
    frameLast_ff <= frameSignal;
    tickCount    <= clr ? 0 : tickCount + int'(panelClockTick);
    frameCount   <= clr ? 0 : frameCount + int'(frameSignal & ~frameLast_ff);
  end
endmodule // lcdc_panel
`default_nettype wire

/* tb_top.sv */
// testbench: registers, clocking, display states, frame flag
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin fails++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tb_top;
  logic clk_sys, rst_n, sleepExec, oscInt, oscLow, oscHigh, clr, hwrite, hready, hreadyout, hresp;
  logic panelClockTick, pixelInvert, pixelForceOn, pixelForceOff, commonStatic, areaActive, frameSignal, frameIrq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [4:0]  commonIndex;
  logic [7:0]  rd;
  lcdc_pkg::lcdc_disp_s  dispCtl;
  lcdc_pkg::lcdc_drive_s driveCtl;
  int fails = 0, check_count = 0, tickCount, frameCount;
  assign hready = hreadyout;
  lcdc_top i_lcdc_top (.clk_sys, .rst_n, .sleepExec, .internalOscTick(oscInt), .lowSpeedOscTick(oscLow),
    .highSpeedOscTick(oscHigh), .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .panelClockTick, .dispCtl, .driveCtl, .pixelInvert, .pixelForceOn, .pixelForceOff,
    .commonStatic, .areaActive, .frameSignal, .commonIndex, .frameIrq);
  lcdc_panel i_lcdc_panel (.clk_sys, .clr, .panelClockTick, .frameSignal, .tickCount, .frameCount);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////
  task automatic bus(input logic [15:0] a, input logic wr, input logic [7:0] d);
    haddr  <= {16'h0000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    rd = hrdata[7:0];
  endtask
  task automatic rchk(input string n, input logic [15:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    `CHK(n, e, rd)
  endtask
  // counts over whole periods, so the divider phase does not matter
  task automatic span(input int n);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic results();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rchk("clk", lcdc_pkg::ADDR_CLK_SEL, 8'h04);
    rchk("dctl", lcdc_pkg::ADDR_DISP_CTL, 8'hd0);
    rchk("cadj", lcdc_pkg::ADDR_CONTRAST, 8'h07);
    rchk("cctl", lcdc_pkg::ADDR_FRM_DUTY, 8'h33);
    rchk("vreg", lcdc_pkg::ADDR_VREG, 8'h00);
    rchk("imsk", lcdc_pkg::ADDR_IRQ_MASK, 8'h00);
    rchk("iflg", lcdc_pkg::ADDR_IRQ_FLAG, 8'h00);
    bus(16'h50a4, 1'b1, 8'h5a);
    rchk("hole", 16'h50a4, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_clock();
    oscInt  <= 1'b1;
    oscLow  <= 1'b1;
    oscHigh <= 1'b1;
    bus(lcdc_pkg::ADDR_FRM_DUTY, 1'b1, 8'h00);
    bus(lcdc_pkg::ADDR_CLK_SEL, 1'b1, 8'h05);
    span(320);
    `CHK("lowTicks", 320, tickCount)
    `CHK("frames", 10, frameCount)
    // source and divider move while the gate is off, except the 0x48 and the later 0x04 writes that turn the gate off while changing both
    bus(lcdc_pkg::ADDR_CLK_SEL, 1'b1, 8'h04);
    bus(lcdc_pkg::ADDR_CLK_SEL, 1'b1, 8'h00);
    bus(lcdc_pkg::ADDR_CLK_SEL, 1'b1, 8'h01);
    span(320);
    `CHK("div32", 10, tickCount)
    bus(lcdc_pkg::ADDR_CLK_SEL, 1'b1, 8'h48);
    bus(lcdc_pkg::ADDR_CLK_SEL, 1'b1, 8'h49);
    span(1024);
    `CHK("div512", 2, tickCount)
    bus(lcdc_pkg::ADDR_CLK_SEL, 1'b1, 8'h04);
    span(64);
    `CHK("gateOff", 0, tickCount)
    bus(lcdc_pkg::ADDR_CLK_SEL, 1'b1, 8'h05);
    $display("test clock done");
  endtask
  task automatic t_states();
    for (int s = 0; s < 4; s++) begin
      bus(lcdc_pkg::ADDR_DISP_CTL, 1'b1, 8'hc0 | 8'(s));
      @(posedge clk_sys);
      `CHK("forceOn", s == 2, pixelForceOn)
      `CHK("forceOff", s == 3, pixelForceOff)
      `CHK("static", s == 3, commonStatic)
      `CHK("invert", s != 3, pixelInvert)
      if (s == 0) `CHK("ref", 4'h0, driveCtl.refLevel)
      `CHK("regOn", s != 0, driveCtl.regulatorOn)
    end
    bus(lcdc_pkg::ADDR_DISP_CTL, 1'b1, 8'hd2);
    @(posedge clk_sys);
    `CHK("normalPol", 1'b0, pixelInvert)
    bus(lcdc_pkg::ADDR_CONTRAST, 1'b1, 8'h0f);
    @(posedge clk_sys);
    `CHK("dark", 4'hf, driveCtl.contrastLevel)
    $display("test states done");
  endtask
  task automatic t_area();
    bus(lcdc_pkg::ADDR_DISP_CTL, 1'b1, 8'h31);
    @(posedge clk_sys);
    `CHK("area8", 1'b0, areaActive)
    `CHK("segDesc", 1'b0, dispCtl.segAscending)
    `CHK("comDesc", 1'b0, dispCtl.comAscending)
    bus(lcdc_pkg::ADDR_FRM_DUTY, 1'b1, 8'h01);
    @(posedge clk_sys);
    `CHK("area16", 1'b1, areaActive)
    $display("test area done");
  endtask
  task automatic t_irq();
    bus(lcdc_pkg::ADDR_FRM_DUTY, 1'b1, 8'hf3);
    bus(lcdc_pkg::ADDR_IRQ_FLAG, 1'b1, 8'h01);
    @(posedge frameSignal);
    repeat (3) @(posedge clk_sys);
    `CHK("masked", 1'b0, frameIrq)
    `CHK("comIdx", 5'h00, commonIndex)
    rchk("flagSet", lcdc_pkg::ADDR_IRQ_FLAG, 8'h01);
    bus(lcdc_pkg::ADDR_IRQ_MASK, 1'b1, 8'h01);
    @(posedge clk_sys);
    `CHK("irqOn", 1'b1, frameIrq)
    bus(lcdc_pkg::ADDR_IRQ_FLAG, 1'b1, 8'h00);
    @(posedge clk_sys);
    `CHK("zeroKeeps", 1'b1, frameIrq)
    bus(lcdc_pkg::ADDR_IRQ_FLAG, 1'b1, 8'h01);
    @(posedge clk_sys);
    `CHK("irqOff", 1'b0, frameIrq)
    rchk("flagClr", lcdc_pkg::ADDR_IRQ_FLAG, 8'h00);
    $display("test irq done");
  endtask
  task automatic t_sleep();
    bus(lcdc_pkg::ADDR_DISP_CTL, 1'b1, 8'hd1);
    sleepExec <= 1'b1;
    @(posedge clk_sys);
    sleepExec <= 1'b0;
    @(posedge clk_sys);
    `CHK("sleepOff", lcdc_pkg::DSP_OFF, dispCtl.displayState)
    rchk("dctlSleep", lcdc_pkg::ADDR_DISP_CTL, 8'hd0);
    `CHK("resp", 1'b0, hresp)
    $display("test sleep done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    results();
  end
  initial begin
    {rst_n, sleepExec, oscInt, oscLow, oscHigh, clr, hwrite} = 7'h00;
    {haddr, hwdata, htrans} = 66'h0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_clock();
    t_states();
    t_area();
    t_irq();
    t_sleep();
    results();
  end
endmodule // tb_top
`default_nettype wire
